// ---- common/lin_uart_map.vh ----
// register map and field constants for the lin/uart register block
`ifndef LIN_UART_MAP_VH
`define LIN_UART_MAP_VH
// register indexes: printed offsets are not all multiples of four, so the
// byte address on the bus is index*4
`define IDX_CONTROL 8'hc8
`define IDX_STATUS 8'hc9
`define IDX_IRQ_ENABLE 8'hca
`define IDX_ERROR 8'hcb
`define IDX_BIT_TIMING 8'hcc
`define IDX_BAUD_LOW 8'hcd
`define IDX_BAUD_HIGH 8'hce
`define IDX_LENGTH 8'hcf
`define IDX_IDENT 8'hd0
`define IDX_SELECT 8'hd1
`define IDX_DATA 8'hd2
`define IDX_ENGINE 8'hd3
// reset values, samples per bit minimum and length limit
`define RST_BIT_TIMING 8'h20
`define RST_SAMPLES 6'h20
`define SPB_MIN 6'h08
`define LEN_MAX 4'h8
// control field positions
`define CTL_SWRES 7
`define CTL_PROTOCOL_VERSION_SELECT 6
`define CTL_ENA 3
// command codes
`define CMD_RX_HDR 3'h0
`define CMD_TX_HDR 3'h1
`define CMD_RX_RSP 3'h2
`define CMD_TX_RSP 3'h3
`define CMD_UART_OFF 3'h4
// soft reset duration in clocks
`define SWRES_CYCLES 4'h4
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- hw/lin_uart_regs.v ----
// register control and status block of a combined lin/uart controller
// Contract
// - lin config: standard, nocrc/noto, noto, listen
// - uart config: none, even, odd parity, listen
// - enable bit turns controller on/off
// - commands ignored while enable clear
// - lin command codes 000..011 decoded
// - uart 100 off, 11x rx, 1x1 tx
// - id status reports identifiers 60..63
// - busy flag at status bit 4
// - error flag is or of errors
// - write one clears flags, error clears all
// - enables at bits 3..0 gate flags
// - uart data read clears error, rx
// - uart data write clears tx done
// - id flag and tx flag set events
// - error register bit order abort..bit error
// - resync disable bit, default enabled
// - samples per bit: default 32, 8..63
// - sample period is divider plus one
// - lin tx/rx lengths clamped to eight
// - lin 1.3 length code to size
// - identifier 6 bit or 4 bit
// - lin data access auto-increments index unless disabled
// - uart data port single byte register
// - index wraps from seven to zero
// - version bit: 0 lin 2.1, 1 lin 1.3
// - soft reset bit self clears
//
// Decided for this implementation: the AXI4-Lite register port.
`include "lin_uart_map.vh"
module lin_uart_regs (
  // clock and reset
  input wire mclk,
  input wire reset,
  // axi4-lite write address
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // frame engine events and state
  input wire ev_identifier,
  input wire ev_tx_done,
  input wire ev_rx_done,
  input wire [7:0] ev_errors,
  input wire engine_busy,
  input wire [5:0] rx_identifier,
  input wire [7:0] rx_byte,
  input wire rx_byte_valid,
  input wire [2:0] engine_index,
  input wire [7:0] engine_byte,
  input wire engine_byte_we,
  // configuration towards the frame engine
  output reg engine_enable,
  output reg engine_reset,
  output reg cmd_strobe,
  output reg [2:0] cmd_code,
  output reg uart_rx_enable,
  output reg uart_tx_enable,
  output reg lin_13,
  output reg checksum_on,
  output reg timeout_on,
  output reg listen_on,
  output reg [1:0] parity_mode,
  output reg resync_on,
  output reg [5:0] sample_count,
  output reg [12:0] sample_period,
  output reg [3:0] tx_count,
  output reg [3:0] rx_count,
  output reg [5:0] frame_id_out,
  output reg [7:0] tx_byte,
  output reg tx_byte_load,
  output reg [7:0] engine_rdata,
  output reg irq
);
  // software visible registers
  reg [7:0] control;
  reg [2:0] status_flags;
  reg [3:0] irq_enable;
  reg [7:0] error_flags;
  reg resync_disable;
  reg [5:0] samples_per_bit;
  reg [11:0] baud_divider;
  reg [7:0] data_length;
  reg [5:0] frame_id;
  reg increment_disable;
  reg [2:0] buffer_index;
  reg [7:0] uart_rx_byte;
  reg [7:0] response_buffer [0:7];
  reg [3:0] swres_count;
  reg cmd_written; // control written with enable set
  // write channel latches
  reg aw_held, w_held;
  reg [7:0] aw_index;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  integer i;
  // byte address to register index
  function [7:0] addr_index;
    input [31:0] addr;
    begin
      addr_index = addr[9:2];
    end
  endfunction
  // clamp a length nibble to eight
  function [3:0] clamp8;
    input [3:0] len;
    begin
      clamp8 = (len > `LEN_MAX) ? `LEN_MAX : len;
    end
  endfunction
  // lin 1.3 length code to byte count
  function [3:0] legacy_size;
    input [1:0] code;
    begin
      case (code)
        2'h2: legacy_size = 4'h4;
        2'h3: legacy_size = 4'h8;
        default: legacy_size = 4'h2;
      endcase
    end
  endfunction
  wire uart_mode = control[2];
  wire enabled = control[`CTL_ENA];
  wire [1:0] config_select = control[5:4];
  wire [2:0] command_field = control[2:0];
  wire protocol_version_select = control[`CTL_PROTOCOL_VERSION_SELECT];
  wire error_flag = |error_flags;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_lane0 = w_strb[0];
  wire [7:0] wbyte = w_data[7:0];
  wire do_read = s_axi_arvalid && s_axi_arready;
  wire [7:0] ar_index = addr_index(s_axi_araddr);
  wire wr_data = do_write && wr_lane0 && aw_index == `IDX_DATA;
  wire rd_data = do_read && ar_index == `IDX_DATA;
  wire wr_status = do_write && wr_lane0 && aw_index == `IDX_STATUS;
  wire clr_err = wr_status && wbyte[3];
  wire [7:0] full_id = {2'h0, frame_id};
  wire [2:0] identifier_status = (rx_identifier[5:2] == 4'hf) ?
    {1'b1, rx_identifier[1:0]} : 3'h0;
  // read data multiplexer
  reg [7:0] rd_byte;
  reg rd_ok;
  always @*
  begin
    rd_ok = 1'b1;
    rd_byte = 8'h00;
    case (ar_index)
      `IDX_CONTROL: rd_byte = control;
      `IDX_STATUS: rd_byte = {identifier_status, engine_busy, error_flag,
        status_flags[2:0]};
      `IDX_IRQ_ENABLE: rd_byte = {4'h0, irq_enable};
      `IDX_ERROR: rd_byte = error_flags;
      `IDX_BIT_TIMING: rd_byte = {resync_disable, 1'b0, samples_per_bit};
      `IDX_BAUD_LOW: rd_byte = baud_divider[7:0];
      `IDX_BAUD_HIGH: rd_byte = {4'h0, baud_divider[11:8]};
      `IDX_LENGTH: rd_byte = data_length;
      `IDX_IDENT: rd_byte = full_id;
      `IDX_SELECT: rd_byte = {4'h0, increment_disable, buffer_index};
      `IDX_DATA: rd_byte = uart_mode ? uart_rx_byte :
        response_buffer[buffer_index];
      default: rd_ok = 1'b0;
    endcase
  end
  // axi channel handshakes
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_index <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_index <= addr_index(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_index >= `IDX_CONTROL && aw_index <= `IDX_DATA)
          ? `RESP_OKAY : `RESP_SLVERR;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (do_read)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
  // register file, flags and buffer
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      control <= 8'h00;
      status_flags <= 3'h0;
      irq_enable <= 4'h0;
      error_flags <= 8'h00;
      resync_disable <= 1'b0;
      samples_per_bit <= `RST_SAMPLES;
      baud_divider <= 12'h000;
      data_length <= 8'h00;
      frame_id <= 6'h00;
      increment_disable <= 1'b0;
      buffer_index <= 3'h0;
      uart_rx_byte <= 8'h00;
      swres_count <= 4'h0;
      tx_byte <= 8'h00;
      tx_byte_load <= 1'b0;
      cmd_written <= 1'b0;
      for (i = 0; i < 8; i = i + 1)
        response_buffer[i] <= 8'h00;
    end
    else if (swres_count != 4'h0)
    begin
      // soft reset: hold defaults, then drop the request bit
      swres_count <= swres_count - 4'h1;
      control <= (swres_count == 4'h1) ? 8'h00 : 8'h80;
      status_flags <= 3'h0;
      error_flags <= 8'h00;
      buffer_index <= 3'h0;
      cmd_written <= 1'b0;
      tx_byte_load <= 1'b0;
    end
    else
    begin
      tx_byte_load <= 1'b0;
      cmd_written <= 1'b0;
      // error flags: set wins over clear
      error_flags <= (clr_err ? 8'h00 : error_flags) | ev_errors;
      if (uart_mode && rd_data)
        error_flags <= ev_errors;
      // status flags: write one clears, events win
      status_flags[2] <= (status_flags[2] && !(wr_status && wbyte[2]))
        || ev_identifier;
      status_flags[1] <= (status_flags[1] && !(wr_status && wbyte[1])
        && !(uart_mode && wr_data)) || ev_tx_done;
      status_flags[0] <= (status_flags[0] && !(wr_status && wbyte[0])
        && !(uart_mode && rd_data)) || ev_rx_done;
      if (rx_byte_valid)
        uart_rx_byte <= rx_byte;
      if (engine_byte_we)
        response_buffer[engine_index] <= engine_byte;
      if (do_write && wr_lane0)
      begin
        case (aw_index)
          `IDX_CONTROL:
          begin
            control <= wbyte;
            if (wbyte[`CTL_SWRES])
              swres_count <= `SWRES_CYCLES;
            cmd_written <= wbyte[`CTL_ENA];
          end
          `IDX_IRQ_ENABLE: irq_enable <= wbyte[3:0];
          `IDX_BIT_TIMING:
          begin
            resync_disable <= wbyte[7];
            samples_per_bit <= (wbyte[5:0] < `SPB_MIN) ? `SPB_MIN :
              wbyte[5:0];
          end
          `IDX_BAUD_LOW: baud_divider[7:0] <= wbyte;
          `IDX_BAUD_HIGH: baud_divider[11:8] <= wbyte[3:0];
          `IDX_LENGTH: data_length <= wbyte;
          `IDX_IDENT: frame_id <= wbyte[5:0];
          `IDX_SELECT:
          begin
            increment_disable <= wbyte[3];
            buffer_index <= wbyte[2:0];
          end
          `IDX_DATA:
          begin
            if (uart_mode)
            begin
              tx_byte <= wbyte;
              tx_byte_load <= 1'b1;
            end
            else
              response_buffer[buffer_index] <= wbyte;
          end
          default: ;
        endcase
      end
      // index steps and wraps on each lin data access while increment_disable is clear
      if ((wr_data || rd_data) && !uart_mode && !increment_disable)
        buffer_index <= buffer_index + 3'h1;
    end
  end
  // derived configuration towards the engine
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      engine_enable <= 1'b0;
      engine_reset <= 1'b0;
      cmd_strobe <= 1'b0;
      cmd_code <= `CMD_RX_HDR;
      uart_rx_enable <= 1'b0;
      uart_tx_enable <= 1'b0;
      lin_13 <= 1'b0;
      checksum_on <= 1'b0;
      timeout_on <= 1'b0;
      listen_on <= 1'b0;
      parity_mode <= 2'h0;
      resync_on <= 1'b1;
      sample_count <= `RST_SAMPLES;
      sample_period <= 13'h0001;
      tx_count <= 4'h0;
      rx_count <= 4'h0;
      frame_id_out <= 6'h00;
      engine_rdata <= 8'h00;
      irq <= 1'b0;
    end
    else
    begin
      engine_enable <= enabled;
      engine_reset <= swres_count != 4'h0;
      cmd_strobe <= cmd_written;
      cmd_code <= enabled ? command_field : `CMD_RX_HDR;
      uart_rx_enable <= enabled && command_field[2] && command_field[1];
      uart_tx_enable <= enabled && command_field[2] && command_field[0];
      lin_13 <= protocol_version_select;
      listen_on <= config_select == 2'h3;
      if (uart_mode)
      begin
        checksum_on <= 1'b0;
        timeout_on <= 1'b0;
        parity_mode <= (config_select == 2'h3) ? 2'h0 : config_select;
        tx_count <= 4'h1;
        rx_count <= 4'h1;
      end
      else
      begin
        checksum_on <= config_select != 2'h1;
        timeout_on <= config_select[0] == config_select[1];
        parity_mode <= 2'h0;
        tx_count <= protocol_version_select ? legacy_size(frame_id[5:4])
          : clamp8(data_length[7:4]);
        rx_count <= protocol_version_select ? legacy_size(frame_id[5:4])
          : clamp8(data_length[3:0]);
      end
      frame_id_out <= protocol_version_select ? {2'h0, frame_id[3:0]} :
        frame_id;
      resync_on <= !resync_disable;
      sample_count <= samples_per_bit;
      sample_period <= {1'b0, baud_divider} + 13'h0001;
      engine_rdata <= response_buffer[engine_index];
      irq <= |({error_flag, status_flags[2:0]} & irq_enable);
    end
  end
endmodule // lin_uart_regs

// ---- testbench/lin_uart_regs_checker.sv ----
// assertion checker for the lin/uart register block
module lin_uart_regs_checker (
  // clock and reset
  input wire mclk,
  input wire reset,
  // engine configuration
  input wire engine_enable,
  input wire engine_reset,
  input wire cmd_strobe,
  input wire [2:0] cmd_code,
  input wire uart_rx_enable,
  input wire uart_tx_enable,
  input wire checksum_on,
  input wire timeout_on,
  input wire listen_on,
  input wire [1:0] parity_mode,
  input wire [5:0] sample_count,
  input wire [3:0] tx_count,
  input wire [3:0] rx_count,
  input wire tx_byte_load
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // command gating and decode
  property p_gate;
    !engine_enable |-> cmd_code == 3'h0 && !cmd_strobe;
  endproperty
  a_gate: assert property (p_gate) else $error("command while off");
  property p_strobe;
    cmd_strobe |=> !cmd_strobe;
  endproperty
  a_strobe: assert property (p_strobe) else $error("long strobe");
  property p_uart;
    engine_enable && cmd_code[2] |-> uart_rx_enable == cmd_code[1]
      && uart_tx_enable == cmd_code[0];
  endproperty
  a_uart: assert property (p_uart) else $error("uart enables");
  // configuration field decode
  property p_listen;
    engine_enable && !cmd_code[2] && listen_on |-> checksum_on && timeout_on;
  endproperty
  a_listen: assert property (p_listen) else $error("lin listen");
  property p_nocrc;
    engine_enable && !cmd_code[2] && !checksum_on |-> !timeout_on
      && !listen_on;
  endproperty
  a_nocrc: assert property (p_nocrc) else $error("lin no checksum");
  property p_par;
    engine_enable && cmd_code[2] |-> parity_mode != 2'h3
      && !(listen_on && parity_mode != 2'h0);
  endproperty
  a_par: assert property (p_par) else $error("uart parity");
  // limits on counts, soft reset span and load pulse
  property p_spb;
    sample_count >= 6'h08;
  endproperty
  a_spb: assert property (p_spb) else $error("samples below min");
  property p_len;
    tx_count <= 4'h8 && rx_count <= 4'h8;
  endproperty
  a_len: assert property (p_len) else $error("length not clamped");
  property p_swres;
    $rose(engine_reset) |-> engine_reset [*4] ##1 !engine_reset;
  endproperty
  a_swres: assert property (p_swres) else $error("soft reset span");
  property p_load;
    tx_byte_load |=> !tx_byte_load;
  endproperty
  a_load: assert property (p_load) else $error("long load");
  // main scenarios
  c_strobe: cover property (cmd_strobe);
  c_swres: cover property ($rose(engine_reset));
  c_load: cover property (tx_byte_load);
  c_listen: cover property (listen_on && checksum_on);
endmodule // lin_uart_regs_checker

bind lin_uart_regs lin_uart_regs_checker u_lin_uart_regs_checker (.*);

// ---- testbench/lin_engine_model.sv ----
// behavioural frame engine facing the register block
`include "lin_uart_map.vh"
module lin_engine_model (
  // clock and reset
  input wire mclk,
  input wire reset,
  // requests from the register block
  input wire cmd_strobe,
  input wire [2:0] cmd_code,
  input wire [7:0] tx_byte,
  input wire tx_byte_load,
  // events and data back
  output reg ev_identifier,
  output reg ev_tx_done,
  output reg ev_rx_done,
  output wire engine_busy,
  output reg [7:0] rx_byte,
  output reg rx_byte_valid,
  output reg [2:0] engine_index,
  output reg [7:0] engine_byte,
  output reg engine_byte_we
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [4:0] cnt;
  reg [2:0] op;
  assign engine_busy = cnt != 5'h00;
  // command runs 20 cycles, event at the end, uart loops back inverted
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      cnt <= 5'h00;
      op <= 3'h0;
      {ev_identifier, ev_tx_done, ev_rx_done, rx_byte_valid} <= 4'h0;
      {engine_byte_we, engine_index, engine_byte, rx_byte} <= 20'h0;
    end
    else
    begin
      ev_identifier <= cnt == 5'h01 && op == `CMD_TX_HDR;
      ev_tx_done <= cnt == 5'h01 && op == `CMD_TX_RSP;
      ev_rx_done <= (cnt == 5'h01 && op == `CMD_RX_RSP) || tx_byte_load;
      engine_byte_we <= op == `CMD_RX_RSP && cnt > 5'h01 && cnt < 5'h0a;
      engine_index <= 3'h1 - cnt[2:0];
      engine_byte <= {5'h14, 3'h1 - cnt[2:0]};
      rx_byte_valid <= tx_byte_load;
      rx_byte <= ~tx_byte;
      if (cmd_strobe)
        op <= cmd_code;
      cnt <= cmd_strobe ? 5'h14 : cnt - {4'h0, engine_busy};
    end
  end
endmodule // lin_engine_model

// ---- testbench/lin_uart_regs_test.sv ----
// self-checking bench for the lin/uart register block
`include "lin_uart_map.vh"
module lin_uart_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, reset;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb, tx_count, rx_count;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, ev_identifier, ev_tx_done;
  logic [1:0] s_axi_bresp, s_axi_rresp, parity_mode;
  logic ev_rx_done, engine_busy, rx_byte_valid, engine_byte_we;
  logic [7:0] ev_errors, rx_byte, engine_byte, tx_byte, engine_rdata;
  logic [5:0] rx_identifier, sample_count, frame_id_out;
  logic [2:0] engine_index, cmd_code;
  logic engine_enable, engine_reset, cmd_strobe, uart_rx_enable;
  logic uart_tx_enable, lin_13, checksum_on, timeout_on, listen_on;
  logic resync_on, tx_byte_load, irq;
  logic [12:0] sample_period;
  int mismatches = 0;
  int tests_run = 0;
  lin_uart_regs u_lin_uart_regs (.*);
  lin_engine_model u_lin_engine_model (.*);
  // clock
  initial
  begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input [31:0] g, input [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // axi4-lite write of one register byte
  task automatic wr(input [7:0] i, input [7:0] d, input [1:0] er = 2'h0);
    reg aw, w;
    @(posedge mclk);
    aw = 1;
    w = 1;
    s_axi_awaddr <= {22'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (aw || w || s_axi_bvalid !== 1'b1)
    begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) aw = 0;
      if (s_axi_wready === 1'b1) w = 0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    s_axi_bready <= 0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  // axi4-lite read compared against expected byte
  task automatic rd(input [7:0] i, input [7:0] e, input [1:0] er = 2'h0);
    reg a;
    @(posedge mclk);
    a = 1;
    s_axi_araddr <= {22'h0, i, 2'h0};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (a || s_axi_rvalid !== 1'b1)
    begin
      @(posedge mclk);
      if (s_axi_arready === 1'b1) a = 0;
      s_axi_arvalid <= a;
    end
    s_axi_rready <= 0;
    chk(s_axi_rdata, {24'h0, e});
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic errs(input [7:0] e);
    @(posedge mclk);
    ev_errors <= e;
    @(posedge mclk);
    ev_errors <= 8'h00;
  endtask
  task wrap_up;
    $display("mismatches %0d of %0d checks", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog
  initial
  begin
    wt(20000);
    mismatches++;
    wrap_up;
  end
  // main sequence
  initial
  begin
    reset = 1;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_wstrb = 4'hf;
    ev_errors = 8'h00;
    rx_identifier = 6'h00;
    wt(16);
    reset <= 0;
    for (logic [7:0] i = `IDX_CONTROL; i <= `IDX_DATA; i++)
      if (i != `IDX_IDENT)
        rd(i, i == `IDX_BIT_TIMING ? `RST_BIT_TIMING : 8'h00);
    chk(32'(sample_period), 1);
    rd(8'h00, 8'h00, `RESP_SLVERR);
    wr(8'h00, 8'hff, `RESP_SLVERR);
    wr(`IDX_CONTROL, 8'h01);
    wt(30);
    rd(`IDX_STATUS, 8'h00);
    chk(32'(cmd_code), 0);
    for (int k = 0; k < 4; k++)
    begin
      wr(`IDX_CONTROL, 8'(k * 16 + 8));
      wt(3);
      chk(32'(engine_enable), 1);
      chk(32'(checksum_on), k != 1);
      chk(32'(timeout_on), k == 0 || k == 3);
      chk(32'(listen_on), k == 3);
      wr(`IDX_CONTROL, 8'(k * 17 + 12));
      wt(3);
      chk(32'(parity_mode), k == 3 ? 0 : k);
      chk(32'(listen_on), k == 3);
      chk(32'(uart_rx_enable), k / 2);
      chk(32'(uart_tx_enable), k % 2);
    end
    wt(30);
    wr(`IDX_CONTROL, 8'h09);
    rd(`IDX_STATUS, 8'h10);
    wt(30);
    rd(`IDX_STATUS, 8'h04);
    wr(`IDX_IRQ_ENABLE, 8'h04);
    wt(3);
    chk(32'(irq), 1);
    wr(`IDX_IRQ_ENABLE, 8'h0b);
    wt(3);
    chk(32'(irq), 0);
    wr(`IDX_STATUS, 8'h04);
    rd(`IDX_STATUS, 8'h00);
    wr(`IDX_CONTROL, 8'h0b);
    wt(30);
    rd(`IDX_STATUS, 8'h02);
    wr(`IDX_IRQ_ENABLE, 8'h02);
    wt(3);
    chk(32'(irq), 1);
    wr(`IDX_CONTROL, 8'h0d);
    wt(30);
    wr(`IDX_DATA, 8'h5a);
    wt(3);
    chk(32'(tx_byte), 32'h5a);
    rd(`IDX_STATUS, 8'h01);
    chk(32'(irq), 0);
    errs(8'h20);
    rd(`IDX_STATUS, 8'h09);
    rd(`IDX_DATA, 8'ha5);
    rd(`IDX_STATUS, 8'h00);
    wr(`IDX_CONTROL, 8'h08);
    wt(30);
    errs(8'h81);
    rd(`IDX_ERROR, 8'h81);
    rd(`IDX_STATUS, 8'h08);
    wr(`IDX_STATUS, 8'h08);
    rd(`IDX_ERROR, 8'h00);
    for (int k = 0; k < 5; k++)
    begin
      rx_identifier <= k < 4 ? 6'(60 + k) : 6'h05;
      wt(3);
      rd(`IDX_STATUS, k < 4 ? 8'(128 + 32 * k) : 8'h00);
    end
    wr(`IDX_CONTROL, 8'h0a);
    wt(30);
    wr(`IDX_SELECT, 8'h00);
    for (int k = 0; k < 9; k++)
      rd(`IDX_DATA, 8'(160 + k % 8));
    wr(`IDX_DATA, 8'h3c);
    wt(3);
    chk(32'(engine_rdata), 32'h3c);
    rd(`IDX_SELECT, 8'h02);
    wr(`IDX_SELECT, 8'h0b);
    rd(`IDX_DATA, 8'ha3);
    rd(`IDX_DATA, 8'ha3);
    rd(`IDX_SELECT, 8'h0b);
    wr(`IDX_BAUD_LOW, 8'h34);
    wr(`IDX_BAUD_HIGH, 8'h01);
    wt(3);
    chk(32'(sample_period), 32'h135);
    wr(`IDX_BIT_TIMING, 8'h85);
    wt(3);
    chk(32'(sample_count), 8);
    chk(32'(resync_on), 0);
    wr(`IDX_BIT_TIMING, 8'h3f);
    wr(`IDX_LENGTH, 8'h9a);
    wt(3);
    chk(32'(sample_count), 63);
    chk({tx_count, rx_count}, 32'h88);
    wr(`IDX_LENGTH, 8'h35);
    wr(`IDX_IDENT, 8'h2a);
    wt(3);
    chk({tx_count, rx_count}, 32'h35);
    chk(32'(frame_id_out), 32'h2a);
    wr(`IDX_CONTROL, 8'h40);
    wt(3);
    chk(32'(lin_13), 1);
    chk(32'(frame_id_out[3:0]), 32'ha);
    chk({tx_count, rx_count}, 32'h44);
    errs(8'h02);
    wr(`IDX_CONTROL, 8'h80);
    wt(12);
    rd(`IDX_CONTROL, 8'h00);
    rd(`IDX_ERROR, 8'h00);
    rd(`IDX_STATUS, 8'h00);
    wrap_up;
  end
endmodule // lin_uart_regs_test
